// >>> src/mdr_pkg.sv
package mdr_pkg;

  // Operation codes issued by the integer pipeline
  typedef enum logic [3:0] {
    MDR_OP_MULT   = 4'h0,
    MDR_OP_MULTU  = 4'h1,
    MDR_OP_PACC   = 4'h2,
    MDR_OP_PACCU  = 4'h3,
    MDR_OP_PSUB   = 4'h4,
    MDR_OP_PSUBU  = 4'h5,
    MDR_OP_MUL    = 4'h6,
    MDR_OP_DIV    = 4'h7,
    MDR_OP_DIVU   = 4'h8,
    MDR_OP_MFUP   = 4'h9,
    MDR_OP_MFBOT  = 4'hA,
    MDR_OP_MTUP   = 4'hB,
    MDR_OP_MTBOT  = 4'hC
  } mdr_op_type;

  localparam int          MDR_DATA_W    = 32;
  localparam int          MDR_HALF_W    = 16;
  localparam logic [5:0]  MDR_DIV_ITERS = 6'h20;
  localparam logic [5:0]  MDR_SKIP_8    = 6'h17;
  localparam logic [5:0]  MDR_SKIP_16   = 6'h0F;
  localparam logic [5:0]  MDR_SKIP_24   = 6'h07;
  localparam logic [31:0] MDR_RESET_VAL = 32'h0000_0000;

endpackage

// >>> src/mdr_divider.sv
`timescale 1ns/1ps
module mdr_divider
  import mdr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Request
  input  wire logic        start_i,
  input  wire logic        signed_i,
  input  wire logic [31:0] dividend_source_i,
  input  wire logic [31:0] second_operand_i,
  // Result
  output logic             busy_o,
  output logic             done_o,
  output logic [31:0]      quot_o,
  output logic [31:0]      rem_o
);

  logic [31:0] rem_q, rem_d, quo_q, quo_d, dvs_q, dvs_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d, done_q, done_d;
  logic        negq_q, negq_d, negr_q, negr_d;

  function automatic logic [31:0] mdr_abs(input logic [31:0] v,
                                          input logic        s);
    mdr_abs = (s && v[31]) ? 32'(-v) : v;
  endfunction

  logic [31:0] a_abs;
  logic [32:0] trial;
  logic [5:0]  skip;

  always_comb begin
    a_abs  = mdr_abs(dividend_source_i, signed_i);
    trial  = {rem_q, quo_q[31]} - {1'b0, dvs_q};
    rem_d  = rem_q;
    quo_d  = quo_q;
    dvs_d  = dvs_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    negq_d = negq_q;
    negr_d = negr_q;
    // Early-out on magnitude width of dividend
    if (a_abs[31:8] == 24'h000000) begin
      skip = MDR_SKIP_8; // [RQ7]
    end else if (a_abs[31:16] == 16'h0000) begin
      skip = MDR_SKIP_16; // [RQ7]
    end else if (a_abs[31:24] == 8'h00) begin
      skip = MDR_SKIP_24; // [RQ7]
    end else begin
      skip = 6'h00;
    end
    if (start_i && !busy_q) begin
      busy_d = 1'b1;
      dvs_d  = mdr_abs(second_operand_i, signed_i);
      rem_d  = 32'h0000_0000;
      quo_d  = a_abs << skip;
      cnt_d  = MDR_DIV_ITERS - skip; // [RQ7]
      negq_d = signed_i && (dividend_source_i[31] ^ second_operand_i[31]);
      negr_d = signed_i && dividend_source_i[31];
    end else if (busy_q) begin
      // One quotient bit per clock
      if (!trial[32]) begin
        rem_d = trial[31:0];
        quo_d = {quo_q[30:0], 1'b1}; // [RQ7]
      end else begin
        rem_d = {rem_q[30:0], quo_q[31]};
        quo_d = {quo_q[30:0], 1'b0};
      end
      cnt_d = 6'(cnt_q - 6'h01);
      if (cnt_q == 6'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rem_q  <= MDR_RESET_VAL;
      quo_q  <= MDR_RESET_VAL;
      dvs_q  <= MDR_RESET_VAL;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      negq_q <= 1'b0;
      negr_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      dvs_q  <= dvs_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      negq_q <= negq_d;
      negr_q <= negr_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign quot_o = negq_q ? 32'(-quo_q) : quo_q;
  assign rem_o  = negr_q ? 32'(-rem_q) : rem_q;

endmodule

// >>> src/mdr_unit.sv
// Function
// RQ1 - Pair-targeted multiplies and divides write the result register pair.
// RQ2 - Move instructions copy upper or lower result register to a GPR.
// RQ3 - GPR-targeted multiply returns low product word directly to a GPR.
// RQ4 - Accumulate-add adds product to the 64-bit result pair.
// RQ5 - Accumulate-subtract subtracts product from the 64-bit result pair.
// RQ6 - 16-bit second operand takes one array pass; 32-bit takes two.
// RQ7 - Divide makes one bit per clock, skipping 23, 15 or 7 iterations.
// RQ8 - Any unit instruction during an active divide stalls the pipeline.
// RQ9 - Back-to-back full-width multiplies issue at most every two clocks.
// RQ10 - The result pair forms one 64-bit value, upper word most significant.
`timescale 1ns/1ps
module mdr_unit
  import mdr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Issue port
  input  wire logic             issue_valid_i,
  input  wire mdr_op_type       issue_op_i,
  input  wire logic [31:0]      dividend_source_i,
  input  wire logic [31:0]      second_operand_i,
  input  wire logic [4:0]       issue_dest_i,
  output logic                  issue_stall_o,
  // General register write-back
  output logic                  gpr_we_o,
  output logic [4:0]            gpr_addr_o,
  output logic [31:0]           gpr_data_o,
  // Result pair view
  output logic [31:0]           top_result_register_o,
  output logic [31:0]           bottom_result_register_o,
  output logic                  busy_o
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    MDR_IDLE,
    MDR_PASS2,
    MDR_DIVIDE
  } mdr_state_type;

  mdr_state_type state_q, state_d;
  logic [31:0]   top_q, top_d, bot_q, bot_d;
  logic [63:0]   prod_q, prod_d;
  mdr_op_type    op_q, op_d;
  logic [4:0]    dest_q, dest_d;
  logic          we_q, we_d;
  logic [4:0]    waddr_q, waddr_d;
  logic [31:0]   wdata_q, wdata_d;
  logic [31:0]   opa_q, opa_d;
  logic [15:0]   opb_q, opb_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_signed_op(input mdr_op_type op);
    is_signed_op = (op == MDR_OP_MULT) || (op == MDR_OP_PACC) ||
                   (op == MDR_OP_PSUB) || (op == MDR_OP_MUL) ||
                   (op == MDR_OP_DIV);
  endfunction

  function automatic logic is_mult_op(input mdr_op_type op);
    is_mult_op = (op == MDR_OP_MULT) || (op == MDR_OP_MULTU) ||
                 (op == MDR_OP_PACC) || (op == MDR_OP_PACCU) ||
                 (op == MDR_OP_PSUB) || (op == MDR_OP_PSUBU) ||
                 (op == MDR_OP_MUL);
  endfunction

  // Partial product of 32-bit a with a 16-bit slice, 64-bit result
  function automatic logic [63:0] part_mul(input logic [31:0] a,
                                           input logic [15:0] b,
                                           input logic        sa,
                                           input logic        sb);
    logic signed [32:0] ax;
    logic signed [16:0] bx;
    logic signed [49:0] p;
    ax = {sa & a[31], a};
    bx = {sb & b[15], b};
    p  = ax * bx;
    part_mul = 64'(signed'(p));
  endfunction

  // Fold a finished 64-bit product into the result pair
  function automatic logic [63:0] fold(input mdr_op_type  op,
                                       input logic [63:0] acc,
                                       input logic [63:0] p);
    if (op == MDR_OP_PACC || op == MDR_OP_PACCU) begin
      fold = acc + p; // [RQ4] [RQ10]
    end else if (op == MDR_OP_PSUB || op == MDR_OP_PSUBU) begin
      fold = acc - p; // [RQ5] [RQ10]
    end else begin
      fold = p; // [RQ1]
    end
  endfunction

  // ****************************************
  // Divider
  // ****************************************
  logic        div_start, div_busy, div_done;
  logic [31:0] div_quot, div_rem;

  mdr_divider u_div (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .start_i           (div_start),
    .signed_i          (issue_op_i == MDR_OP_DIV),
    .dividend_source_i (dividend_source_i),
    .second_operand_i  (second_operand_i),
    .busy_o            (div_busy),
    .done_o            (div_done),
    .quot_o            (div_quot),
    .rem_o             (div_rem)
  );

  // ****************************************
  // Control
  // ****************************************
  logic        sgn, narrow, accept;
  logic [63:0] p_nar, p_upr, full, acc;

  always_comb begin
    sgn      = is_signed_op(issue_op_i);
    // Operand fits in 16 bits when its upper half is a sign/zero extension
    narrow   = sgn ? (second_operand_i[31:15] == {17{second_operand_i[15]}})
                   : (second_operand_i[31:16] == 16'h0000); // [RQ6]
    issue_stall_o = issue_valid_i && // [RQ8] [RQ9]
                    (state_q == MDR_DIVIDE || state_q == MDR_PASS2);
    accept   = issue_valid_i && !issue_stall_o;
    div_start = accept &&
                (issue_op_i == MDR_OP_DIV || issue_op_i == MDR_OP_DIVU);
    p_nar    = part_mul(dividend_source_i, second_operand_i[15:0], sgn,
                        narrow && sgn);
    acc      = {top_q, bot_q}; // [RQ10]
    // Second pass adds the upper-half partial product shifted by 16;
    // operands come from the held copy, the issue port has moved on
    p_upr    = part_mul(opa_q, opb_q,
                        is_signed_op(op_q), is_signed_op(op_q));
    full     = prod_q + {p_upr[47:0], 16'h0000};
    opa_d    = opa_q;
    opb_d    = opb_q;
    state_d  = state_q;
    top_d    = top_q;
    bot_d    = bot_q;
    prod_d   = prod_q;
    op_d     = op_q;
    dest_d   = dest_q;
    we_d     = 1'b0;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    case (state_q)
      MDR_IDLE: begin
        if (accept && is_mult_op(issue_op_i)) begin
          if (narrow) begin
            if (issue_op_i == MDR_OP_MUL) begin
              we_d    = 1'b1; // [RQ3]
              waddr_d = issue_dest_i;
              wdata_d = p_nar[31:0];
            end else begin
              {top_d, bot_d} = fold(issue_op_i, acc, p_nar); // [RQ1]
            end
          end else begin
            // Low 16-bit slice unsigned on first pass
            prod_d  = part_mul(dividend_source_i, second_operand_i[15:0],
                               sgn, 1'b0);
            op_d    = issue_op_i;
            dest_d  = issue_dest_i;
            opa_d   = dividend_source_i;
            opb_d   = second_operand_i[31:16];
            state_d = MDR_PASS2; // [RQ6] [RQ9]
          end
        end else if (div_start) begin
          state_d = MDR_DIVIDE;
        end else if (accept && issue_op_i == MDR_OP_MFUP) begin
          we_d    = 1'b1; // [RQ2]
          waddr_d = issue_dest_i;
          wdata_d = top_q;
        end else if (accept && issue_op_i == MDR_OP_MFBOT) begin
          we_d    = 1'b1; // [RQ2]
          waddr_d = issue_dest_i;
          wdata_d = bot_q;
        end else if (accept && issue_op_i == MDR_OP_MTUP) begin
          top_d = dividend_source_i;
        end else if (accept && issue_op_i == MDR_OP_MTBOT) begin
          bot_d = dividend_source_i;
        end
      end
      MDR_PASS2: begin
        state_d = MDR_IDLE;
        if (op_q == MDR_OP_MUL) begin
          we_d    = 1'b1; // [RQ3]
          waddr_d = dest_q;
          wdata_d = full[31:0];
        end else begin
          {top_d, bot_d} = fold(op_q, acc, full); // [RQ4] [RQ5]
        end
      end
      MDR_DIVIDE: begin
        if (div_done) begin
          top_d   = div_rem; // [RQ1]
          bot_d   = div_quot; // [RQ1]
          state_d = MDR_IDLE; // [RQ8]
        end
      end
      default: begin
        state_d = MDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= MDR_IDLE;
      top_q   <= MDR_RESET_VAL;
      bot_q   <= MDR_RESET_VAL;
      prod_q  <= 64'h0000_0000_0000_0000;
      op_q    <= MDR_OP_MULT;
      dest_q  <= 5'h00;
      we_q    <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= MDR_RESET_VAL;
      opa_q   <= MDR_RESET_VAL;
      opb_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      top_q   <= top_d;
      bot_q   <= bot_d;
      prod_q  <= prod_d;
      op_q    <= op_d;
      dest_q  <= dest_d;
      we_q    <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      opa_q   <= opa_d;
      opb_q   <= opb_d;
    end
  end

  assign gpr_we_o                 = we_q;
  assign gpr_addr_o               = waddr_q;
  assign gpr_data_o               = wdata_q;
  assign top_result_register_o    = top_q;
  assign bottom_result_register_o = bot_q;
  assign busy_o                   = (state_q != MDR_IDLE) || div_busy;

endmodule

// >>> tb/mdr_unit_sva.sv
`timescale 1ns/1ps
module mdr_unit_sva
  import mdr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Issue port
  input  wire logic        issue_valid_i,
  input  wire mdr_op_type  issue_op_i,
  input  wire logic [31:0] dividend_source_i,
  input  wire logic [31:0] second_operand_i,
  input  wire logic [4:0]  issue_dest_i,
  input  wire logic        issue_stall_o,
  // Results
  input  wire logic        gpr_we_o,
  input  wire logic [4:0]  gpr_addr_o,
  input  wire logic [31:0] gpr_data_o,
  input  wire logic [31:0] top_result_register_o,
  input  wire logic [31:0] bottom_result_register_o,
  input  wire logic        busy_o
);
  logic        take;
  logic        sgn;
  logic        wide;
  logic [63:0] prod;
  logic [31:0] plow;
  logic [63:0] pair;
  always_comb begin
    take = issue_valid_i && !issue_stall_o;
    sgn  = issue_op_i inside {MDR_OP_MULT, MDR_OP_PACC, MDR_OP_PSUB,
                              MDR_OP_MUL};
    wide = second_operand_i[31:16] !=
           (sgn ? {16{second_operand_i[15]}} : 16'h0000);
    prod = {{32{sgn & dividend_source_i[31]}}, dividend_source_i} *
           {{32{sgn & second_operand_i[31]}}, second_operand_i};
    plow = prod[31:0];
    pair = {top_result_register_o, bottom_result_register_o};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence mul_s(logic w);
    take && issue_op_i <= MDR_OP_MUL && wide == w;
  endsequence
  sequence narrow_s(mdr_op_type op);
    take && issue_op_i == op && !wide;
  endsequence
  stall_on_busy_a: assert property (
    issue_valid_i && busy_o |-> issue_stall_o) else $error("no stall");
  stall_cause_a: assert property (
    issue_stall_o |-> issue_valid_i && busy_o) else $error("bad stall");
  wide_hold_a: assert property (
    mul_s(1'b1) |=> busy_o ##1 !busy_o) else $error("wide pacing");
  narrow_free_a: assert property (
    mul_s(1'b0) |=> !busy_o) else $error("narrow busy");
  mult_pair_a: assert property (
    narrow_s(MDR_OP_MULT) |=> pair == $past(prod)) else $error("mult pair");
  pacc_pair_a: assert property (
    narrow_s(MDR_OP_PACC) |=> pair == $past(pair) + $past(prod))
    else $error("accumulate pair");
  psub_pair_a: assert property (
    narrow_s(MDR_OP_PSUBU) |=> pair == $past(pair) - $past(prod))
    else $error("subtract pair");
  mul_gpr_a: assert property (
    narrow_s(MDR_OP_MUL) |=> gpr_we_o && gpr_data_o == $past(plow) &&
    gpr_addr_o == $past(issue_dest_i)) else $error("mul write");
  mfup_gpr_a: assert property (
    take && issue_op_i == MDR_OP_MFUP |=> gpr_we_o &&
    gpr_data_o == $past(top_result_register_o)) else $error("move upper");
  div_time_a: assert property (
    take && issue_op_i == MDR_OP_DIVU && dividend_source_i[31:8] == 24'h0
    |=> busy_o[*8] ##[1:4] !busy_o) else $error("divide time");
endmodule
bind mdr_unit mdr_unit_sva sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i),
  .dividend_source_i(dividend_source_i), .second_operand_i(second_operand_i),
  .issue_dest_i(issue_dest_i), .issue_stall_o(issue_stall_o),
  .gpr_we_o(gpr_we_o), .gpr_addr_o(gpr_addr_o), .gpr_data_o(gpr_data_o),
  .top_result_register_o(top_result_register_o),
  .bottom_result_register_o(bottom_result_register_o), .busy_o(busy_o));

// >>> tb/mdr_pipe_model.sv
`timescale 1ns/1ps
module mdr_pipe_model
  import mdr_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   stall_i,
  output logic        valid_o,
  output mdr_op_type  op_o,
  output logic [31:0] src_o,
  output logic [31:0] opnd_o,
  output logic [4:0]  dest_o,
  output logic        hang_o
);
  initial begin
    valid_o = 1'b0;
    op_o    = MDR_OP_MULT;
    src_o   = 32'h0;
    opnd_o  = 32'h0;
    dest_o  = 5'h0;
    hang_o  = 1'b0;
  end
  // Offer an op and hold it until an edge takes it
  task automatic issue(input mdr_op_type op, input logic [31:0] a, b,
                       input logic [4:0] d);
    logic s;
    int   n;
    valid_o <= 1'b1;
    op_o    <= op;
    src_o   <= a;
    opnd_o  <= b;
    dest_o  <= d;
    n = 0;
    do begin
      @(negedge clk_i);
      s = stall_i;
      @(posedge clk_i);
      n++;
    end while (s !== 1'b0 && n < 200);
    if (s !== 1'b0) hang_o <= 1'b1;
  endtask
  task automatic idle();
    valid_o <= 1'b0;
    src_o   <= ~src_o;
    opnd_o  <= ~opnd_o;
  endtask
endmodule

// >>> tb/mdr_unit_test.sv
`timescale 1ns/1ps
module mdr_unit_test
  import mdr_pkg::*;
;
  logic        clk_i;
  logic        rst_n_i = 1'b0;
  logic        issue_valid_i, issue_stall_o, gpr_we_o, busy_o, hang;
  mdr_op_type  issue_op_i;
  logic [31:0] dividend_source_i, second_operand_i, gpr_data_o;
  logic [31:0] top_result_register_o, bottom_result_register_o;
  logic [4:0]  issue_dest_i, gpr_addr_o;
  logic [31:0] rng = 32'hF6F9;
  logic [63:0] pair = 64'h0;
  logic [36:0] gq[$];
  logic [36:0] eq[$];
  int          err_count = 0;
  int          checks = 0;
  mdr_unit dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i),
    .dividend_source_i(dividend_source_i), .second_operand_i(second_operand_i),
    .issue_dest_i(issue_dest_i), .issue_stall_o(issue_stall_o),
    .gpr_we_o(gpr_we_o), .gpr_addr_o(gpr_addr_o), .gpr_data_o(gpr_data_o),
    .top_result_register_o(top_result_register_o),
    .bottom_result_register_o(bottom_result_register_o), .busy_o(busy_o));
  mdr_pipe_model pipe (.clk_i(clk_i), .stall_i(issue_stall_o),
    .valid_o(issue_valid_i), .op_o(issue_op_i), .src_o(dividend_source_i),
    .opnd_o(second_operand_i), .dest_o(issue_dest_i), .hang_o(hang));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (gpr_we_o === 1'b1) gq.push_back({gpr_addr_o, gpr_data_o});
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [31:0] ext(logic [31:0] v, int w, logic s);
    ext = v << (32 - w);
    ext = s ? 32'($signed(ext) >>> (32 - w)) : ext >> (32 - w);
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Let the unit go idle, then compare the pair and the register writes
  task automatic settle();
    int n;
    n = 0;
    pipe.idle();
    do begin
      @(negedge clk_i);
      n++;
    end while ((busy_o !== 1'b0 || n < 3) && n < 60);
    @(negedge clk_i);
    chk({63'h0, hang}, 64'h0);
    chk(64'(n < 60), 64'h1);
    chk({top_result_register_o, bottom_result_register_o}, pair);
    chk(64'(gq.size()), 64'(eq.size()));
    while (gq.size() > 0 && eq.size() > 0) begin
      chk(gq.pop_front(), eq.pop_front());
    end
    if (hang || n >= 60) results();
    else @(posedge clk_i);
  endtask
  task automatic step();
    mdr_op_type  op;
    logic [31:0] r, a, b;
    logic [63:0] p;
    logic        s;
    int          qa, qb;
    r  = rnd();
    op = mdr_op_type'(r[3:0] % 4'hD);
    s  = op inside {MDR_OP_MULT, MDR_OP_PACC, MDR_OP_PSUB, MDR_OP_MUL,
                    MDR_OP_DIV};
    a  = ext(rnd(), 8 * (int'(r[5:4]) + 1), s);
    b  = ext(rnd(), r[6] ? 16 : 32, s);
    if (b == 32'h0 || (s && b == 32'hFFFF_FFFF)) b = 32'h3;
    pipe.issue(op, a, b, r[11:7]);
    p  = {{32{s & a[31]}}, a} * {{32{s & b[31]}}, b};
    qa = a;
    qb = b;
    case (op)
      MDR_OP_MULT, MDR_OP_MULTU: pair = p;
      MDR_OP_PACC, MDR_OP_PACCU: pair += p;
      MDR_OP_PSUB, MDR_OP_PSUBU: pair -= p;
      MDR_OP_MUL: eq.push_back({r[11:7], p[31:0]});
      MDR_OP_DIV: pair = {32'(qa % qb), 32'(qa / qb)};
      MDR_OP_DIVU: pair = {a % b, a / b};
      MDR_OP_MFUP: eq.push_back({r[11:7], pair[63:32]});
      MDR_OP_MFBOT: eq.push_back({r[11:7], pair[31:0]});
      MDR_OP_MTUP: pair[63:32] = a;
      default: pair[31:0] = a;
    endcase
    if (r[12]) settle();
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    $display("test reset done");
    repeat (400) step();
    settle();
    $display("test random done");
    results();
  end
endmodule
